// ===== src/i2cs_slave.sv
`timescale 1ns/100ps
// How it works
// - Ninth clock is the acknowledge slot.
// - Transmitter releases data; low means accepted.
// - Record far-end acknowledge in status bit.
// - Hold enables set: send software acknowledge value.
// - Hold enables clear: hardware acknowledges.
// - No hardware acknowledge on overflow, or on full buffer without overwrite enable.
// - Acknowledge-time flag after eighth falling edge.
// - Acknowledge-time flag needs a hold enable.
// - Four modes, 7-bit and 10-bit addressing.
// - Start/stop modes flag Start, Restart, Stop.
// - Matched first byte loads buffer, interrupts.
// - High-byte mismatch goes idle silently.
// - 7-bit match ignores byte LSB.
// - 10-bit high byte is 11110 A9 A8 0.
// - After high byte: address-update flag, hold clock.
// - Low byte compared on all eight bits.
// - After low byte: flag, update flag, hold.
// - Address write clears address-update flag.
// - 10-bit read needs prior full write match.
// - Write address clears read/write, loads, acknowledges.
// - Overflow on address gives not-acknowledge.
// - Interrupt every byte addressed to it; software clears it.
// - Stretch enable holds clock after received bytes.
// - Interrupt flag set on ninth falling edge.
module i2cs_slave (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic scl_i, // Bus clock level, also the link clock.
  input wire logic sda_i, // Bus data level.
  output logic scl_o, // Bus clock drive value, always low.
  output logic scl_oe, // High while the clock is held low.
  output logic sda_o, // Bus data drive value, always low.
  output logic sda_oe, // High while acknowledging.
  input wire i2cs_pkg::i2cs_ctl_t ctl, // Software controls and strobes.
  output i2cs_pkg::i2cs_sts_t sts // Software visible status.
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain.

  logic rst_l1_ff;
  logic rst_l2_ff;
  logic tog_l_ff;
  logic samp_l_ff;

  // The system reset is brought into the link domain before use.
  always_ff @(posedge scl_i) begin
    rst_l1_ff <= reset;
    rst_l2_ff <= rst_l1_ff;
  end

  // Each rising bus clock samples data and flips a toggle for the other side.
  always_ff @(posedge scl_i) begin
    if (rst_l2_ff) begin
      tog_l_ff <= 1'b0;
      samp_l_ff <= 1'b0;
    end else begin
      tog_l_ff <= ~tog_l_ff;
      samp_l_ff <= sda_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system domain.

  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic tog_s1_ff, tog_s2_ff, tog_s3_ff, tog_s4_ff;
  logic bit_s1_ff, bit_s2_ff, bit_s3_ff;

  // Two flops before any logic looks at a bus level; the third is for edges.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
      {tog_s1_ff, tog_s2_ff, tog_s3_ff, tog_s4_ff} <= 4'h0;
      {bit_s1_ff, bit_s2_ff, bit_s3_ff} <= 3'h0;
    end else begin
      {scl_s3_ff, scl_s2_ff, scl_s1_ff} <= {scl_s2_ff, scl_s1_ff, scl_i};
      {sda_s3_ff, sda_s2_ff, sda_s1_ff} <= {sda_s2_ff, sda_s1_ff, sda_i};
      {tog_s4_ff, tog_s3_ff, tog_s2_ff, tog_s1_ff} <=
        {tog_s3_ff, tog_s2_ff, tog_s1_ff, tog_l_ff};
      {bit_s3_ff, bit_s2_ff, bit_s1_ff} <= {bit_s2_ff, bit_s1_ff, samp_l_ff};
    end
  end

  // The sampled bit is read at the same stage, the third, where the toggle edge is seen.
  logic rise_ev, fall_ev, start_ev, stop_ev, rx_bit;
  assign rise_ev = tog_s3_ff ^ tog_s4_ff;
  assign rx_bit = bit_s3_ff;
  assign fall_ev = scl_s3_ff & ~scl_s2_ff;
  assign start_ev = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign stop_ev = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address comparison.

  // Shared by the decision logic and by an assertion.
  function automatic logic addr_match(input i2cs_pkg::i2cs_state_t st,
                                      input logic [7:0] rx,
                                      input logic [7:0] adr,
                                      input logic ten,
                                      input logic was_addressed);
    logic m;
    m = 1'b1;
    if (st == i2cs_pkg::ST_ADDR_HI) begin
      if (ten) begin
        m = (rx[7:3] == i2cs_pkg::TEN_HDR) && (rx[2:1] == adr[2:1])
            && (!rx[0] || was_addressed);
      end else begin
        m = rx[7:1] == adr[7:1];
      end
    end else if (st == i2cs_pkg::ST_ADDR_LO) begin
      m = rx == adr;
    end
    return m;
  endfunction : addr_match

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencing.

  i2cs_pkg::i2cs_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] buf_ff;
  logic [7:0] adr_ff;
  logic bf_ff, ov_ff, ackt_ff, ua_ff, ua_hold_ff, ackst_ff, rw_ff, ckp_ff, intf_ff;
  logic pend_ff, acked_ff, ten_ok_ff, sda_oe_ff;

  logic mode_ok, ten_mode, sp_mode, is_addr, sw_ack, matched, blocked, ack_ok;
  logic byte_done, ack_rise, end_byte;

  assign mode_ok = ctl.port_mode_field inside {i2cs_pkg::MODE_7BIT, i2cs_pkg::MODE_10BIT,
                                               i2cs_pkg::MODE_7BIT_SP,
                                               i2cs_pkg::MODE_10BIT_SP};
  assign ten_mode = ctl.port_mode_field[i2cs_pkg::MODE_TEN_POS];
  assign sp_mode = ctl.port_mode_field[i2cs_pkg::MODE_SP_POS];
  assign is_addr = (state_ff == i2cs_pkg::ST_ADDR_HI) || (state_ff == i2cs_pkg::ST_ADDR_LO);
  assign sw_ack = is_addr ? ctl.address_hold_enable : ctl.data_hold_enable;
  assign matched = addr_match(state_ff, shift_ff, adr_ff, ten_mode, ten_ok_ff);
  // Overwrite enable lets a full buffer be overwritten, but never an overflow.
  assign blocked = ov_ff || (bf_ff && !ctl.buffer_overwrite_enable);
  assign ack_ok = matched && !blocked;
  assign byte_done = fall_ev && (cnt_ff == i2cs_pkg::CNT_BYTE) && (state_ff != i2cs_pkg::ST_IDLE);
  assign ack_rise = rise_ev && (cnt_ff == i2cs_pkg::CNT_BYTE);
  assign end_byte = fall_ev && (cnt_ff == i2cs_pkg::CNT_ACK);

  // Bit counter and shift register; a Start restarts the count at any time.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_ff <= i2cs_pkg::CNT_ZERO;
      shift_ff <= i2cs_pkg::RST_BYTE;
    end else if (start_ev || stop_ev) begin
      cnt_ff <= i2cs_pkg::CNT_ZERO;
    end else if (rise_ev && cnt_ff < i2cs_pkg::CNT_BYTE) begin
      shift_ff <= {shift_ff[6:0], rx_bit};
      cnt_ff <= cnt_ff + 4'h1;
    end else if (ack_rise) begin
      cnt_ff <= i2cs_pkg::CNT_ACK;
    end else if (end_byte) begin
      cnt_ff <= i2cs_pkg::CNT_ZERO;
    end
  end

  // Address phases, then data. A high-byte mismatch drops back to idle unseen.
  always_ff @(posedge clk_sys) begin
    if (reset || !mode_ok) begin
      state_ff <= i2cs_pkg::ST_IDLE;
      ten_ok_ff <= 1'b0;
    end else if (start_ev) begin
      state_ff <= i2cs_pkg::ST_ADDR_HI;
    end else if (stop_ev) begin
      state_ff <= i2cs_pkg::ST_IDLE;
      ten_ok_ff <= 1'b0;
    end else if (byte_done && !matched && state_ff == i2cs_pkg::ST_ADDR_HI) begin
      state_ff <= i2cs_pkg::ST_IDLE;
    end else if (end_byte) begin
      unique case (state_ff)
        i2cs_pkg::ST_IDLE: state_ff <= i2cs_pkg::ST_IDLE;
        i2cs_pkg::ST_ADDR_HI: begin
          // Read requests hand over to transmission, which lives elsewhere.
          if (!acked_ff || rw_ff) begin
            state_ff <= i2cs_pkg::ST_IDLE;
          end else if (ten_mode) begin
            state_ff <= i2cs_pkg::ST_ADDR_LO;
          end else begin
            state_ff <= i2cs_pkg::ST_DATA;
          end
        end
        i2cs_pkg::ST_ADDR_LO: begin
          state_ff <= acked_ff ? i2cs_pkg::ST_DATA : i2cs_pkg::ST_IDLE;
          ten_ok_ff <= acked_ff;
        end
        i2cs_pkg::ST_DATA: state_ff <= acked_ff ? i2cs_pkg::ST_DATA : i2cs_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge drive.

  // Hardware answers at once; software answers by releasing the held clock.
  always_ff @(posedge clk_sys) begin
    if (reset || start_ev || stop_ev) begin
      pend_ff <= 1'b0;
      acked_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (byte_done && (matched || state_ff == i2cs_pkg::ST_ADDR_LO)) begin
      pend_ff <= sw_ack;
      acked_ff <= !sw_ack && ack_ok;
      sda_oe_ff <= !sw_ack && ack_ok;
    end else if (pend_ff && ctl.ckp_set) begin
      pend_ff <= 1'b0;
      acked_ff <= !ctl.ack_data_bit;
      sda_oe_ff <= !ctl.ack_data_bit;
    end else if (end_byte) begin
      sda_oe_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer, address register and status flags.

  // The buffer loads only for matched, unblocked bytes; a full buffer then overflows.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      buf_ff <= i2cs_pkg::RST_BYTE;
      bf_ff <= 1'b0;
      ov_ff <= 1'b0;
      rw_ff <= 1'b0;
    end else begin
      if (byte_done && ack_ok) begin
        buf_ff <= shift_ff;
      end
      if (byte_done && ack_ok) begin
        bf_ff <= 1'b1;
      end else if (ctl.buf_rd) begin
        bf_ff <= 1'b0;
      end
      if (byte_done && matched && bf_ff) begin
        ov_ff <= 1'b1;
      end else if (ctl.ovf_clr) begin
        ov_ff <= 1'b0;
      end
      if (byte_done && matched && state_ff == i2cs_pkg::ST_ADDR_HI) begin
        rw_ff <= shift_ff[0];
      end
    end
  end

  // Address register; a write also ends the 10-bit address hold.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      adr_ff <= i2cs_pkg::RST_BYTE;
      ua_ff <= 1'b0;
      ua_hold_ff <= 1'b0;
    end else begin
      if (ctl.addr_wr) begin
        adr_ff <= ctl.addr_wr_data;
      end
      // Hardware setting wins over a write in the same cycle.
      if (end_byte && ten_mode && acked_ff && state_ff == i2cs_pkg::ST_ADDR_HI && !rw_ff) begin
        ua_ff <= 1'b1;
        ua_hold_ff <= 1'b1;
      end else if (end_byte && state_ff == i2cs_pkg::ST_ADDR_LO) begin
        ua_ff <= 1'b1;
        ua_hold_ff <= 1'b1;
      end else if (ctl.addr_wr) begin
        ua_ff <= 1'b0;
        ua_hold_ff <= 1'b0;
      end
    end
  end

  // Acknowledge time marks the slot between the eighth and ninth falls.
  always_ff @(posedge clk_sys) begin
    if (reset || start_ev || stop_ev) begin
      ackt_ff <= 1'b0;
    end else if (byte_done && (matched || state_ff == i2cs_pkg::ST_ADDR_LO)) begin
      ackt_ff <= ctl.address_hold_enable || ctl.data_hold_enable;
    end else if (end_byte) begin
      ackt_ff <= 1'b0;
    end
  end

  // The far end's answer is taken on the ninth rising edge.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ackst_ff <= 1'b0;
    end else if (ack_rise && state_ff != i2cs_pkg::ST_IDLE) begin
      ackst_ff <= rx_bit;
    end
  end

  // Interrupt on each handled byte and, in start/stop modes, on conditions.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intf_ff <= 1'b0;
    end else if ((end_byte && (state_ff != i2cs_pkg::ST_IDLE || acked_ff))
                 || (sp_mode && mode_ok && (start_ev || stop_ev))) begin
      intf_ff <= 1'b1;
    end else if (ctl.intr_clr) begin
      intf_ff <= 1'b0;
    end
  end

  // Clock release bit: cleared to stretch after a received byte.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ckp_ff <= i2cs_pkg::RST_CKP;
    end else if (end_byte && ctl.stretch_enable && acked_ff && !rw_ff) begin
      ckp_ff <= 1'b0;
    end else if (ctl.ckp_set) begin
      ckp_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and status.

  // The clock is held by a stretch, an address update or a software answer.
  assign scl_o = 1'b0;
  assign scl_oe = !ckp_ff || ua_hold_ff || pend_ff;
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_ff;

  assign sts.shift_buffer_reg = buf_ff;
  assign sts.slave_address_reg = adr_ff;
  assign sts.buffer_full_flag = bf_ff;
  assign sts.receive_overflow_flag = ov_ff;
  assign sts.ack_time_flag = ackt_ff;
  assign sts.address_update_flag = ua_ff;
  assign sts.ack_status_bit = ackst_ff;
  assign sts.rw_status_bit = rw_ff;
  assign sts.clock_release_bit = ckp_ff;
  assign sts.port_interrupt_flag = intf_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_ack_slot_only;
    sda_oe |-> (cnt_ff == i2cs_pkg::CNT_BYTE || cnt_ff == i2cs_pkg::CNT_ACK);
  endproperty
  a_ack_slot_only: assert property (p_ack_slot_only) else $error("ack outside slot");

  property p_release_after_slot;
    end_byte && !pend_ff |=> !sda_oe;
  endproperty
  a_release_after_slot: assert property (p_release_after_slot)
    else $error("data not released");

  property p_ackst;
    ack_rise && state_ff != i2cs_pkg::ST_IDLE |=> sts.ack_status_bit == $past(rx_bit);
  endproperty
  a_ackst: assert property (p_ackst) else $error("ack status wrong");

  property p_sw_ack;
    pend_ff && ctl.ckp_set |=> sda_oe == !$past(ctl.ack_data_bit);
  endproperty
  a_sw_ack: assert property (p_sw_ack) else $error("software ack value lost");

  property p_hw_ack;
    byte_done && matched && !sw_ack && !blocked |=> sda_oe && !pend_ff;
  endproperty
  a_hw_ack: assert property (p_hw_ack) else $error("hardware ack missing");

  property p_nack_full;
    byte_done && ov_ff |=> !sda_oe;
  endproperty
  a_nack_full: assert property (p_nack_full) else $error("ack on overflow");

  property p_ackt_needs_hold;
    !ctl.address_hold_enable && !ctl.data_hold_enable && byte_done |=> !sts.ack_time_flag;
  endproperty
  a_ackt_needs_hold: assert property (p_ackt_needs_hold) else $error("ack time unexpected");

  property p_ua_clear;
    ctl.addr_wr && !end_byte |=> !sts.address_update_flag;
  endproperty
  a_ua_clear: assert property (p_ua_clear) else $error("update flag kept");

  property p_int_ninth;
    end_byte && acked_ff |=> sts.port_interrupt_flag;
  endproperty
  a_int_ninth: assert property (p_int_ninth) else $error("no interrupt");

  property p_mismatch_idle;
    byte_done && !matched && state_ff == i2cs_pkg::ST_ADDR_HI
      |=> (state_ff == i2cs_pkg::ST_IDLE && !sda_oe && !$rose(sts.buffer_full_flag))[*2];
  endproperty
  a_mismatch_idle: assert property (p_mismatch_idle) else $error("mismatch not silent");

  c_data_byte: cover property (end_byte && state_ff == i2cs_pkg::ST_DATA && acked_ff);
  c_ten_lo: cover property (end_byte && state_ff == i2cs_pkg::ST_ADDR_LO);
  c_stretch: cover property (scl_oe && !ckp_ff);
  c_nack: cover property (byte_done && matched && blocked);

endmodule : i2cs_slave

// ===== src/i2cs_pkg.sv
package i2cs_pkg;

  // Port mode codes for the four slave modes.
  localparam logic [3:0] MODE_7BIT = 4'h6;
  localparam logic [3:0] MODE_10BIT = 4'h7;
  localparam logic [3:0] MODE_7BIT_SP = 4'hE;
  localparam logic [3:0] MODE_10BIT_SP = 4'hF;
  localparam int MODE_TEN_POS = 0;
  localparam int MODE_SP_POS = 3;

  // Fixed upper pattern of the 10-bit high address byte.
  localparam logic [4:0] TEN_HDR = 5'h1E;

  // Bit counter values: eight data bits, then the acknowledge slot.
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK = 4'h9;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_CKP = 1'b1;

  // Slave sequencing states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR_HI = 4'h2,
    ST_ADDR_LO = 4'h4,
    ST_DATA = 4'h8
  } i2cs_state_t;

  // Software side controls and strobes.
  typedef struct packed {
    logic [3:0] port_mode_field;
    logic address_hold_enable;
    logic data_hold_enable;
    logic ack_data_bit;
    logic buffer_overwrite_enable;
    logic stretch_enable;
    logic addr_wr;
    logic [7:0] addr_wr_data;
    logic buf_rd;
    logic ckp_set;
    logic intr_clr;
    logic ovf_clr;
  } i2cs_ctl_t;

  // Software side status.
  typedef struct packed {
    logic [7:0] shift_buffer_reg;
    logic [7:0] slave_address_reg;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic ack_time_flag;
    logic address_update_flag;
    logic ack_status_bit;
    logic rw_status_bit;
    logic clock_release_bit;
    logic port_interrupt_flag;
  } i2cs_sts_t;

endpackage : i2cs_pkg

// ===== verification/i2cs_bus_master.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural bus master. The testbench resolves the wires with pull-ups.
module i2cs_bus_master #(
  parameter int HALF = 1016 // Half bit time in ns, well above the slave minimum.
) (
  input wire logic scl, // Resolved bus clock.
  input wire logic sda, // Resolved bus data.
  output logic scl_m, // Clock drive, low pulls the wire.
  output logic sda_m, // Data drive, low pulls the wire.
  output logic hung // Set when a stretched clock never came back.
);
  // Both lines released at time zero.
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    hung = 1'b0;
  end

  // Release the clock, then wait for a stretching slave; the wait is bounded.
  task automatic rise;
    int n;
    scl_m = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 2000) begin
      #50;
      n++;
    end
    if (n == 2000) hung = 1'b1;
  endtask : rise

  // Fast pulses with data high only run the link domain through reset.
  task automatic idle_pulses;
    repeat (2) begin
      #100 scl_m = 1'b0;
      #100 scl_m = 1'b1;
    end
  endtask : idle_pulses

  // Data falls while the clock is high.
  task automatic start;
    sda_m = 1'b1;
    rise();
    #HALF sda_m = 1'b0;
    #HALF scl_m = 1'b0;
  endtask : start

  // Data rises while the clock is high.
  task automatic stop;
    #(HALF / 2) sda_m = 1'b0;
    #(HALF / 2) rise();
    #HALF sda_m = 1'b1;
    #HALF;
  endtask : stop

  // Eight bits MSB first, then a ninth pulse with data released for the answer.
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #(HALF / 2) sda_m = (i == 0) ? 1'b1 : b[i - 1];
      #(HALF / 2) rise();
      ack = sda;
      #HALF scl_m = 1'b0;
    end
  endtask : xfer
endmodule : i2cs_bus_master

// ===== verification/testbench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
  localparam logic [4:0] s_adr = 5'h10;
  localparam logic [4:0] s_rd = 5'h08;
  localparam logic [4:0] s_ckp = 5'h04;
  localparam logic [4:0] s_iclr = 5'h02;
  localparam logic [4:0] s_oclr = 5'h01;
  localparam logic [7:0] hi_adr = 8'h04;
  logic clk_sys;
  logic reset;
  i2cs_pkg::i2cs_ctl_t ctl;
  i2cs_pkg::i2cs_sts_t sts;
  logic scl_o, scl_oe, sda_o, sda_oe;
  logic scl_m, sda_m, hung, ack;
  logic scl_bus, sda_bus;
  logic ack_time_flag_seen = 1'b0;
  int fail_count = 0;
  int compares = 0;
  int n;

  // Open-drain wires with pull-ups: low if any party pulls low.
  assign scl_bus = scl_m & ~(scl_oe & ~scl_o);
  assign sda_bus = sda_m & ~(sda_oe & ~sda_o);

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  i2cs_slave dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .scl_i(scl_bus),
    .sda_i(sda_bus),
    .scl_o(scl_o),
    .scl_oe(scl_oe),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .ctl(ctl),
    .sts(sts)
  );

  i2cs_bus_master master (
    .scl(scl_bus),
    .sda(sda_bus),
    .scl_m(scl_m),
    .sda_m(sda_m),
    .hung(hung)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: status mismatch, saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Software strobes last one clock and are launched just after an edge.
  task automatic strobe(input logic [4:0] s);
    @(posedge clk_sys);
    #1;
    {ctl.addr_wr, ctl.buf_rd, ctl.ckp_set, ctl.intr_clr, ctl.ovf_clr} = s;
    @(posedge clk_sys);
    #1;
    {ctl.addr_wr, ctl.buf_rd, ctl.ckp_set, ctl.intr_clr, ctl.ovf_clr} = 5'h00;
  endtask : strobe

  // Status lands a few clocks after a bus edge; wait past that.
  task automatic settle;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : settle

  // A stuck clock would stall the run, so it ends it instead.
  always @(posedge hung) begin
    fail_count++;
    summarize();
  end

  // The acknowledge-time flag must stay quiet while no hold enable is set.
  always @(posedge clk_sys) begin
    if (sts.ack_time_flag === 1'b1) ack_time_flag_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ctl = '0;
    ctl.port_mode_field = i2cs_pkg::MODE_7BIT;
    reset = 1'b1;
    fork
      master.idle_pulses();
    join_none
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    // The link side leaves its reset only after two more bus clock rises.
    master.idle_pulses();
    // 7-bit write: the address LSB differs from the stored one and still matches.
    ctl.addr_wr_data = 8'hA5;
    strobe(s_adr);
    chk(sts.slave_address_reg, 8'hA5);
    master.start();
    master.xfer(8'hA4, ack);
    settle();
    chk(8'(ack), 8'h00);
    chk(sts.shift_buffer_reg, 8'hA4);
    chk({4'h0, sts.buffer_full_flag, sts.port_interrupt_flag, sts.rw_status_bit,
         sts.ack_status_bit}, 8'h0C);
    // Data byte with stretching: the clock stays low until software lets go.
    strobe(s_rd | s_iclr);
    ctl.stretch_enable = 1'b1;
    master.xfer(8'h3C, ack);
    settle();
    chk(8'(ack), 8'h00);
    chk(sts.shift_buffer_reg, 8'h3C);
    chk({4'h0, sts.port_interrupt_flag, sts.clock_release_bit, scl_oe,
         sts.buffer_full_flag}, 8'h0B);
    ctl.stretch_enable = 1'b0;
    strobe(s_ckp);
    chk({6'h0, sts.clock_release_bit, scl_oe}, 8'h02);
    // With overwrite enabled a full buffer still takes the byte, but overflow is flagged.
    ctl.buffer_overwrite_enable = 1'b1;
    master.xfer(8'h66, ack);
    settle();
    chk({6'h0, ack, sts.receive_overflow_flag}, 8'h01);
    chk(sts.shift_buffer_reg, 8'h66);
    ctl.buffer_overwrite_enable = 1'b0;
    // The buffer was never read, so the next byte is refused.
    master.xfer(8'h5A, ack);
    settle();
    chk(8'(ack), 8'h01);
    chk({6'h0, sts.receive_overflow_flag, sts.ack_status_bit}, 8'h03);
    master.stop();
    strobe(s_rd | s_iclr | s_oclr);
    chk(8'(ack_time_flag_seen), 8'h00);
    // A foreign address leaves no trace.
    master.start();
    master.xfer(8'h10, ack);
    settle();
    chk({5'h0, ack, sts.port_interrupt_flag, sts.buffer_full_flag}, 8'h04);
    master.stop();
    settle();
    // Software answers the address with a refusal once the ack slot is reached.
    ctl.address_hold_enable = 1'b1;
    ctl.ack_data_bit = 1'b1;
    master.start();
    fork
      master.xfer(8'hA4, ack);
      begin
        n = 0;
        while (sts.ack_time_flag !== 1'b1 && n < 300) begin
          @(posedge clk_sys);
          #1;
          n++;
        end
        if (n == 300) begin
          fail_count++;
          summarize();
        end
        chk({6'h0, sts.ack_time_flag, scl_oe}, 8'h03);
        strobe(s_ckp);
      end
    join
    chk(8'(ack), 8'h01);
    master.stop();
    settle();
    ctl.address_hold_enable = 1'b0;
    ctl.ack_data_bit = 1'b0;
    // 10-bit write: high byte, low address handshake, low byte, rearm.
    ctl.port_mode_field = i2cs_pkg::MODE_10BIT;
    ctl.addr_wr_data = hi_adr;
    // The refused address above still filled the buffer, so read it out first.
    strobe(s_adr | s_rd | s_iclr);
    master.start();
    master.xfer({i2cs_pkg::TEN_HDR, hi_adr[2:1], 1'b0}, ack);
    settle();
    chk({5'h0, ack, sts.address_update_flag, scl_oe}, 8'h03);
    ctl.addr_wr_data = 8'h5B;
    strobe(s_adr | s_rd | s_iclr);
    chk({6'h0, sts.address_update_flag, scl_oe}, 8'h00);
    master.xfer(8'h5B, ack);
    settle();
    chk({4'h0, ack, sts.port_interrupt_flag, sts.address_update_flag,
         scl_oe}, 8'h07);
    ctl.addr_wr_data = hi_adr;
    strobe(s_adr | s_iclr);
    chk({6'h0, sts.address_update_flag, scl_oe}, 8'h00);
    master.stop();
    // Start and Stop each raise the interrupt in the two event modes.
    for (int k = 0; k < 2; k++) begin
      settle();
      ctl.port_mode_field = k ? i2cs_pkg::MODE_10BIT_SP : i2cs_pkg::MODE_7BIT_SP;
      strobe(s_iclr);
      master.start();
      settle();
      chk(8'(sts.port_interrupt_flag), 8'h01);
      strobe(s_iclr);
      master.stop();
      settle();
      chk(8'(sts.port_interrupt_flag), 8'h01);
    end
    summarize();
  end
endmodule : testbench
